//--- verilog/otf_defs.vh
// register offsets, field positions, reset values and timing counts
`ifndef OTF_DEFS_VH
`define OTF_DEFS_VH
`define OTF_IDX_TMR_STAT   8'h79
`define OTF_IDX_PPR        8'h7B
`define OTF_IDX_CFG5       8'h7C
`define OTF_IDX_CFG4       8'h7D
`define OTF_IDX_TMR_LIM    8'h7A
`define OTF_IDX_CFG3       8'h78
`define OTF_IDX_CFG1       8'h40
`define OTF_IDX_INT_STAT2  8'h42
`define OTF_IDX_INT_MASK2  8'h75
`define OTF_RST_TMR_STAT   8'h00
`define OTF_RST_PPR        8'h55
`define OTF_RST_CFG5       8'h01
`define OTF_RST_CFG4       8'h00
`define OTF_RST_TMR_LIM    8'h00
`define OTF_RST_CFG3       8'h00
`define OTF_RST_CFG1       8'h00
`define OTF_RST_INT_MASK2  8'h00
`define OTF_CFG5_MASK      8'hEF
`define OTF_CFG4_MASK      8'h2F
`define OTF_CFG1_LOCK      1
`define OTF_CFG3_TMR_EN    1
`define OTF_CFG5_SIGNED    0
`define OTF_CFG5_OFSRNG    1
`define OTF_CFG5_AUXDIR    2
`define OTF_CFG5_AUXPOL    3
`define OTF_CFG5_R1DIS     5
`define OTF_CFG5_LCDIS     6
`define OTF_CFG5_R2DIS     7
`define OTF_INT2_TMR_EVT   5
`define OTF_ROLE_FOURTH_TACHOMETER_INPUT     2'b00
`define OTF_ROLE_OVT       2'b01
`define OTF_ROLE_ALERT     2'b10
`define OTF_ROLE_AUX       2'b11
`define OTF_TICK_NS        22760000
`define OTF_CLK_NS         50
`define OTF_TICK_CYC       (`OTF_TICK_NS / `OTF_CLK_NS)
`define OTF_LIM_OFF64      8'h00
`define OTF_LIM_TWOS       8'h80
`endif

//--- verilog/otf_overtemp_timer_fan_config.v
// register bank: overtemperature assertion timer, fan pulse counts, configuration
//
// Notes on behaviour
// - status bit0 sets on assertion, clears on read
// - beyond 45.52 ms bit0 becomes count lsb
// - bits 7:1 read zero until 45.52 ms
// - reading covers 45.52 ms to 5.80 s
// - writable 8-bit limit, 22.76 ms steps
// - time over limit sets interrupt status2 bit5
// - limit zero interrupts at once on assertion
// - pulse field codes 00..11 count 1..4
// - four 2-bit fields, fan one lowest
// - config bit0 selects signed or offset-64 format
// - config bit1 selects temperature offset range
// - config bit2 sets aux pin direction
// - config bit3 sets aux pin polarity
// - config bits 5..7 zero enable channel limits
// - limit at minimum value means channel disabled
// - lock bit makes configuration read-only
// - reset values 0x55, 0x01, timer zero
// - 2-bit field selects shared pin role
// - mask bit5 suppresses alert for timer event while the pin role is overtemperature
// - config3 bit1 enables timer monitoring
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "otf_defs.vh"
module otf_overtemp_timer_fan_config #(
  parameter TICK_CYC = `OTF_TICK_CYC
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sharedPinIn,
  output reg         sharedPinOut,
  output reg         sharedPinOe,
  input  wire [7:0]  remoteOneLimit,
  input  wire [7:0]  localLimit,
  input  wire [7:0]  remoteTwoLimit,
  output reg  [2:0]  channelLimitEnable,
  output reg  [1:0]  tachPulseCountOne,
  output reg  [1:0]  tachPulseCountTwo,
  output reg  [1:0]  tachPulseCountThree,
  output reg  [1:0]  tachPulseCountFour,
  output reg         signedTempFormat,
  output reg         offsetRangeSelect,
  output reg  [1:0]  sharedPinRole,
  output reg         overtempAsserted,
  output reg         alertOut
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [2:0] pulsesCounted;
    input [1:0] code;
    begin
      pulsesCounted = {1'b0, code} + 3'd1;
    end
  endfunction

  function limitOff;
    input [7:0] lim;
    input       twos;
    begin
      limitOff = twos ? (lim == `OTF_LIM_TWOS) : (lim == `OTF_LIM_OFF64);
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]  tmrStatus_ff;
  reg [7:0]  tmrLimit_ff;
  reg [7:0]  ppr_ff;
  reg [7:0]  cfg5_ff;
  reg [7:0]  cfg4_ff;
  reg [7:0]  cfg3_ff;
  reg [7:0]  cfg1_ff;
  reg [7:0]  intMask2_ff;
  reg        intTmrEvt_ff;
  reg [7:0]  duration_ff;
  reg [31:0] presc_ff;
  reg [2:0]  pinSync_ff;
  reg        lineLvl_ff;
  reg        lineLvlD_ff;

  wire [7:0] idx      = paddr[9:2];
  wire       wordOk   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire       setup    = psel && !penable;
  wire       acc      = psel && penable && pready;
  wire       wrAcc    = acc && pwrite && pstrb[0] && wordOk;
  wire       rdAcc    = acc && !pwrite && wordOk;
  wire       locked   = cfg1_ff[`OTF_CFG1_LOCK];
  wire [7:0] wb       = pwdata[7:0];
  wire       roleOvt  = (cfg4_ff[1:0] == `OTF_ROLE_OVT);
  wire       roleAux  = (cfg4_ff[1:0] == `OTF_ROLE_AUX);
  wire       monOn    = cfg3_ff[`OTF_CFG3_TMR_EN] && roleOvt;
  wire       assertNow = monOn && lineLvl_ff;
  wire       rise     = assertNow && !lineLvlD_ff;
  wire       tick     = assertNow && (presc_ff == TICK_CYC - 1);
  wire       rdStatus = rdAcc && (idx == `OTF_IDX_TMR_STAT);

  reg mapped;
  always @* begin
    mapped = 1'b0;
    case (idx)
      `OTF_IDX_TMR_STAT, `OTF_IDX_TMR_LIM, `OTF_IDX_PPR, `OTF_IDX_CFG5, `OTF_IDX_CFG4,
      `OTF_IDX_CFG3, `OTF_IDX_CFG1, `OTF_IDX_INT_STAT2, `OTF_IDX_INT_MASK2: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pin synchroniser, active-low overtemperature line
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinSync_ff  <= 3'b111;
      lineLvl_ff  <= 1'b0;
      lineLvlD_ff <= 1'b0;
    end else begin
      pinSync_ff <= {pinSync_ff[1:0], sharedPinIn};
      if (pinSync_ff[2] == pinSync_ff[1]) begin
        lineLvl_ff  <= ~pinSync_ff[2];
      end
      lineLvlD_ff <= assertNow;
    end
  end

  // ----------------------------------------------------------------
  // assertion timer
  // ----------------------------------------------------------------
  reg [7:0] nxt_duration;
  reg [7:0] nxt_status;
  always @* begin
    nxt_duration = duration_ff;
    if (rise) begin
      nxt_duration = 8'h00;
    end else if (tick && duration_ff != 8'hFF) begin
      nxt_duration = duration_ff + 8'd1;
    end
    nxt_status = tmrStatus_ff;
    if (rdStatus) begin
      nxt_status = 8'h00;
    end
    if (assertNow) begin
      if (nxt_duration >= 8'd2) begin
        nxt_status = nxt_duration;
      end else begin
        nxt_status = {7'd0, 1'b1};
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_ff     <= 32'd0;
      duration_ff  <= 8'h00;
      tmrStatus_ff <= `OTF_RST_TMR_STAT;
      intTmrEvt_ff <= 1'b0;
    end else begin
      if (rise || !assertNow || tick) begin
        presc_ff <= 32'd0;
      end else begin
        presc_ff <= presc_ff + 32'd1;
      end
      duration_ff  <= nxt_duration;
      tmrStatus_ff <= nxt_status;
      if (assertNow && tmrLimit_ff == 8'h00) begin
        intTmrEvt_ff <= 1'b1;
      end else if (assertNow && duration_ff > tmrLimit_ff) begin
        intTmrEvt_ff <= 1'b1;
      end else if (rdAcc && idx == `OTF_IDX_INT_STAT2) begin
        intTmrEvt_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tmrLimit_ff <= `OTF_RST_TMR_LIM;
      ppr_ff      <= `OTF_RST_PPR;
      cfg5_ff     <= `OTF_RST_CFG5;
      cfg4_ff     <= `OTF_RST_CFG4;
      cfg3_ff     <= `OTF_RST_CFG3;
      cfg1_ff     <= `OTF_RST_CFG1;
      intMask2_ff <= `OTF_RST_INT_MASK2;
    end else if (wrAcc) begin
      case (idx)
        `OTF_IDX_TMR_LIM: begin
          tmrLimit_ff <= wb;
        end
        `OTF_IDX_PPR: begin
          ppr_ff <= wb;
        end
        `OTF_IDX_CFG5: begin
          if (!locked) begin
            cfg5_ff <= wb & `OTF_CFG5_MASK;
          end
        end
        `OTF_IDX_CFG4: begin
          if (!locked) begin
            cfg4_ff <= wb & `OTF_CFG4_MASK;
          end
        end
        `OTF_IDX_CFG3: begin
          if (!locked) begin
            cfg3_ff <= wb;
          end
        end
        `OTF_IDX_CFG1: begin
          if (!locked) begin
            cfg1_ff <= wb;
          end
        end
        `OTF_IDX_INT_MASK2: begin
          intMask2_ff <= wb;
        end
        default: begin
          cfg1_ff <= cfg1_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb answer, no wait states
  // ----------------------------------------------------------------
  reg [7:0] rdByte;
  always @* begin
    rdByte = 8'h00;
    case (idx)
      `OTF_IDX_TMR_STAT:  rdByte = tmrStatus_ff;
      `OTF_IDX_TMR_LIM:   rdByte = tmrLimit_ff;
      `OTF_IDX_PPR:       rdByte = ppr_ff;
      `OTF_IDX_CFG5:      rdByte = cfg5_ff;
      `OTF_IDX_CFG4:      rdByte = cfg4_ff;
      `OTF_IDX_CFG3:      rdByte = cfg3_ff;
      `OTF_IDX_CFG1:      rdByte = cfg1_ff;
      `OTF_IDX_INT_STAT2: rdByte = {2'b00, intTmrEvt_ff, 5'b00000};
      `OTF_IDX_INT_MASK2: rdByte = intMask2_ff;
      default:            rdByte = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= (pwrite || !(wordOk && mapped)) ? 32'h0000_0000 : {24'h00_0000, rdByte};
        pslverr <= !(wordOk && mapped);
      end else if (acc) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs and shared pin
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sharedPinOut        <= 1'b0;
      sharedPinOe         <= 1'b0;
      channelLimitEnable  <= 3'b000;
      tachPulseCountOne   <= 2'b01;
      tachPulseCountTwo   <= 2'b01;
      tachPulseCountThree <= 2'b01;
      tachPulseCountFour  <= 2'b01;
      signedTempFormat    <= 1'b1;
      offsetRangeSelect   <= 1'b0;
      sharedPinRole       <= 2'b00;
      overtempAsserted    <= 1'b0;
      alertOut            <= 1'b0;
    end else begin
      tachPulseCountOne   <= ppr_ff[1:0];
      tachPulseCountTwo   <= ppr_ff[3:2];
      tachPulseCountThree <= ppr_ff[5:4];
      tachPulseCountFour  <= ppr_ff[7:6];
      signedTempFormat    <= cfg5_ff[`OTF_CFG5_SIGNED];
      offsetRangeSelect   <= cfg5_ff[`OTF_CFG5_OFSRNG];
      sharedPinRole       <= cfg4_ff[1:0];
      channelLimitEnable[0] <= !cfg5_ff[`OTF_CFG5_R1DIS] &&
                               !limitOff(remoteOneLimit, cfg5_ff[0]);
      channelLimitEnable[1] <= !cfg5_ff[`OTF_CFG5_LCDIS] &&
                               !limitOff(localLimit, cfg5_ff[0]);
      channelLimitEnable[2] <= !cfg5_ff[`OTF_CFG5_R2DIS] &&
                               !limitOff(remoteTwoLimit, cfg5_ff[0]);
      overtempAsserted    <= assertNow;
      alertOut            <= intTmrEvt_ff && !(roleOvt && intMask2_ff[`OTF_INT2_TMR_EVT]);
      sharedPinOe         <= roleAux && cfg5_ff[`OTF_CFG5_AUXDIR];
      sharedPinOut        <= !cfg5_ff[`OTF_CFG5_AUXPOL];
    end
  end
endmodule

//--- tb/otf_monitor.sv
// assertion checker for the overtemp timer register bank
`timescale 1ns/10ps
module otf_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sharedPinIn,
  input wire logic        sharedPinOe,
  input wire logic [1:0]  sharedPinRole,
  input wire logic [7:0]  remoteOneLimit,
  input wire logic [2:0]  channelLimitEnable,
  input wire logic        signedTempFormat,
  input wire logic [1:0]  tachPulseCountOne,
  input wire logic        overtempAsserted
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  error_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error with data");
  read_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  limit_disable_a: assert property (channelLimitEnable[0] |->
    $past(remoteOneLimit) != (signedTempFormat ? 8'h80 : 8'h00)) else $error("min limit on");
  pin_drive_a: assert property (sharedPinOe |-> sharedPinRole == 2'b11)
    else $error("pin driven off role");
  monitor_role_a: assert property (overtempAsserted |-> sharedPinRole == 2'b01)
    else $error("monitor off role");
  line_idle_a: assert property (sharedPinIn [*6] |=> !overtempAsserted)
    else $error("assert while idle");
  counts_write_a: assert property ($changed(tachPulseCountOne) |->
    $past(psel && penable && pwrite, 2)) else $error("count changed alone");
endmodule
bind otf_overtemp_timer_fan_config otf_monitor otf_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sharedPinIn(sharedPinIn),
  .sharedPinOe(sharedPinOe), .sharedPinRole(sharedPinRole), .remoteOneLimit(remoteOneLimit),
  .channelLimitEnable(channelLimitEnable), .signedTempFormat(signedTempFormat),
  .tachPulseCountOne(tachPulseCountOne), .overtempAsserted(overtempAsserted));

//--- tb/otf_ot_source.sv
// overtemperature line source, driven high when idle and low for each pulse
`timescale 1ns/10ps
module otf_ot_source (
  input  wire logic clk_sys,
  output logic      lineN
);
  initial lineN = 1'b1;
  task automatic pulse(input int n);
    @(posedge clk_sys);
    lineN <= 1'b0;
    repeat (n) @(posedge clk_sys);
    lineN <= 1'b1;
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the overtemp timer register bank
`timescale 1ns/10ps
`include "otf_defs.vh"
module tb_top;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  r1 = 1, lc = 1, r2 = 1, c, mdl [0:255];
  wire  [31:0] prdata;
  wire         pready, pslverr, pinOut, pinOe, ota, alert, sgn, ofs, lineN;
  wire  [2:0]  cle;
  wire  [1:0]  t1, t2, t3, t4, role;
  wire         pin = pinOe ? pinOut : lineN;
  int          bad_count = 0, n_checks = 0, i;
  always #25 clk_sys = ~clk_sys;
  otf_ot_source otf_ot_source_i (.clk_sys(clk_sys), .lineN(lineN));
  otf_overtemp_timer_fan_config #(.TICK_CYC(10)) otf_overtemp_timer_fan_config_i (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sharedPinIn(pin), .sharedPinOut(pinOut), .sharedPinOe(pinOe),
    .remoteOneLimit(r1), .localLimit(lc), .remoteTwoLimit(r2), .channelLimitEnable(cle),
    .tachPulseCountOne(t1), .tachPulseCountTwo(t2), .tachPulseCountThree(t3),
    .tachPulseCountFour(t4), .signedTempFormat(sgn), .offsetRangeSelect(ofs),
    .sharedPinRole(role), .overtempAsserted(ota), .alertOut(alert));
  // ----
  // tasks
  // ----
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    n_checks++;
    if (s !== x) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= ($urandom() & 32'hFFFF_FF00) | d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic lk;
    lk = mdl[`OTF_IDX_CFG1][`OTF_CFG1_LOCK];
    apb(1'b1, idx, d);
    if (!(lk && (idx == `OTF_IDX_CFG5 || idx == `OTF_IDX_CFG4 || idx == `OTF_IDX_CFG3 ||
        idx == `OTF_IDX_CFG1)))
      mdl[idx] = d & (idx == `OTF_IDX_CFG5 ? `OTF_CFG5_MASK :
                      idx == `OTF_IDX_CFG4 ? `OTF_CFG4_MASK : 8'hFF);
  endtask
  task automatic rdx(input logic [7:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    chk("register", {24'h00_0000, x}, q);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [7:0] mn();
    return mdl[`OTF_IDX_CFG5][0] ? `OTF_LIM_TWOS : `OTF_LIM_OFF64;
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    for (i = 0; i < 256; i++) mdl[i] = 8'h00;
    mdl[`OTF_IDX_PPR] = `OTF_RST_PPR;
    mdl[`OTF_IDX_CFG5] = `OTF_RST_CFG5;
    void'($urandom(30821));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    chk("pulse counts", 8'h55, {t4, t3, t2, t1});
    rdx(`OTF_IDX_TMR_STAT, 8'h00);
    rdx(`OTF_IDX_TMR_LIM, 8'h00);
    rdx(`OTF_IDX_CFG5, 8'h01);
    for (i = 0; i < 6; i++) begin
      wr(`OTF_IDX_PPR, i < 4 ? {4{i[1:0]}} : 8'($urandom()));
      settle();
      chk("pulse counts", mdl[`OTF_IDX_PPR], {t4, t3, t2, t1});
      rdx(`OTF_IDX_PPR, mdl[`OTF_IDX_PPR]);
    end
    wr(`OTF_IDX_CFG4, 8'h03);
    for (i = 0; i < 8; i++) begin
      wr(`OTF_IDX_CFG5, 8'($urandom()));
      c = mdl[`OTF_IDX_CFG5];
      r1 <= i[0] ? mn() : 8'($urandom());
      lc <= i[1] ? mn() : 8'($urandom());
      r2 <= i[2] ? mn() : 8'($urandom());
      settle();
      chk("enables", {!c[7] && r2 != mn(), !c[6] && lc != mn(), !c[5] && r1 != mn()}, cle);
      chk("format", {c[1], c[0]}, {ofs, sgn});
      chk("aux pin", {c[2], !c[3]}, {pinOe, pinOut});
      rdx(`OTF_IDX_CFG5, c);
    end
    wr(`OTF_IDX_CFG4, 8'h01);
    wr(`OTF_IDX_CFG3, 8'h02);
    wr(`OTF_IDX_TMR_LIM, 8'h03);
    settle();
    chk("role", 2'b01, role);
    rdx(`OTF_IDX_TMR_LIM, 8'h03);
    otf_ot_source_i.pulse(15);
    settle();
    rdx(`OTF_IDX_TMR_STAT, 8'h01);
    rdx(`OTF_IDX_INT_STAT2, 8'h00);
    otf_ot_source_i.pulse(65);
    settle();
    chk("alert", 1'b1, alert);
    rdx(`OTF_IDX_TMR_STAT, 8'h06);
    rdx(`OTF_IDX_TMR_STAT, 8'h00);
    rdx(`OTF_IDX_INT_STAT2, 8'h20);
    rdx(`OTF_IDX_INT_STAT2, 8'h00);
    wr(`OTF_IDX_TMR_LIM, 8'h00);
    otf_ot_source_i.pulse(4);
    settle();
    chk("alert", 1'b1, alert);
    wr(`OTF_IDX_INT_MASK2, 8'h20);
    settle();
    chk("alert", 1'b0, alert);
    rdx(`OTF_IDX_INT_STAT2, 8'h20);
    otf_ot_source_i.pulse(2700);
    settle();
    rdx(`OTF_IDX_TMR_STAT, 8'hFF);
    wr(`OTF_IDX_CFG1, 8'h02);
    wr(`OTF_IDX_CFG5, ~mdl[`OTF_IDX_CFG5]);
    rdx(`OTF_IDX_CFG5, mdl[`OTF_IDX_CFG5]);
    apb(1'b0, 8'h01, 8'h00);
    chk("error", 1'b1, e);
    summarize();
  end
endmodule
